// File: rtl/port_f_pkg.sv
// Purpose: Constants and helpers for the port F pin multiplexer
// Assumes: AXI4-Lite register access, 32-bit data, one aclk domain
// Notes:   Byte addresses below are word aligned
//
// Notes on behaviour
// - The direction register is write-only and never reads back its bits.
// - Direction bit 7 resets to 1 in modes 1,2,4,5,6 and 0 in mode 7.
// - Pin 7 outputs the system clock when bit 7 is 1, else it is an input.
// - In modes 1,2,4,5,6 pin 6 is the address strobe when enabled, else I/O.
// - In modes 3 and 7 without expansion pins 6..0 are plain I/O.
// - In modes 1,2,4,5,6 pins 5 and 4 are always read and high write strobes.
// - Pin 3 is the low write strobe when expanded and enabled, else direction I/O.
// - In modes 1,2,4,5,6 pins 2 and 1 are column strobes when the bus controller enables them, else I/O.
// - Column/wait pins take their bus role when configured, else are I/O.
// - In modes 3 and 7 with expansion pins 7..3 behave as in bus modes.
// - In modes 3 and 7 with expansion pins 2..0 follow the function control.
// - The output latch is 8-bit read/write, resets to zero, feeds GPIO pins.

package port_f_pkg;

    localparam int          ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0]  OFF_DIR    = 8'h00;
    localparam logic [7:0]  OFF_LATCH  = 8'h04;
    localparam logic [7:0]  OFF_CFG    = 8'h08;
    localparam logic [7:0]  OFF_STATUS = 8'h0C;

    // Configuration register fields
    localparam int          CFG_EXTERNAL_EXPANSION_ENABLE   = 0;
    localparam int          CFG_ADDR_STROBE_OUT_ENABLE   = 1;
    localparam int          CFG_LOW_WRITE_STROBE_OUT_ENABLE  = 2;
    localparam int          CFG_LOWER_COLUMN_STROBE   = 3;
    localparam int          CFG_UPPER_COLUMN_STROBE   = 4;
    localparam int          CFG_WAIT   = 5;
    localparam int          CFG_W      = 6;

    // Status register fields
    localparam int          ST_DRIVE   = 0;
    localparam int          ST_MODE    = 8;
    localparam int          ST_PINS    = 12;

    // Reset values
    localparam logic [7:0]  LATCH_RST  = 8'h00;
    localparam logic [6:0]  DIR_LO_RST = 7'h00;
    localparam logic [5:0]  CFG_RST    = 6'h06;

    // Value returned for a direction register read (arbitrary)
    localparam logic [7:0]  DIR_READ_DEFAULT = 8'hA5;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Modes 1, 2, 4, 5, 6 run the external bus
    function automatic logic is_bus_mode(input logic [2:0] m);
        is_bus_mode = (m == 3'h1) || (m == 3'h2) || (m == 3'h4) ||
                      (m == 3'h5) || (m == 3'h6);
    endfunction

    // Modes 3 and 7 are single-chip unless expanded
    function automatic logic is_single_mode(input logic [2:0] m);
        is_single_mode = (m == 3'h3) || (m == 3'h7);
    endfunction

    // Word match of a bus address against an offset
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        off);
        reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

endpackage

// File: rtl/port_f_pin_select.sv
// Purpose: Per-pin function choice between GPIO and bus-control roles
// Assumes: All inputs on aclk domain or static configuration
// Notes:   Purely combinational

`timescale 1ns/10ps
`default_nettype none

module port_f_pin_select
    import port_f_pkg::*;
(
    // Mode and configuration
    input  wire logic [2:0] mode,
    input  wire logic       external_expansion_enable,
    input  wire logic       addr_strobe_out_enable,
    input  wire logic       low_write_strobe_out_enable,
    input  wire logic [2:0] port_function_ctrl2,
    input  wire logic [2:0] bc_column_wait_en,
    // Port registers
    input  wire logic [7:0] pin_direction_select,
    input  wire logic [7:0] pin_output_latch,
    // Bus controller signals
    input  wire logic       sys_clk_level,
    input  wire logic       address_strobe,
    input  wire logic       read_strobe,
    input  wire logic       high_write_strobe,
    input  wire logic       low_write_strobe,
    input  wire logic       lower_column_strobe,
    input  wire logic       upper_column_strobe,
    // Pin drive
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe_n,
    output logic      [7:0] bus_role
);

    logic       bus_mode;
    logic       expanded;
    logic [2:0] col_sel;
    logic [7:0] role_out;
    logic [7:0] role_oe_n;

    assign bus_mode = is_bus_mode(mode);
    // Single-chip modes follow bus modes once expanded
    assign expanded = bus_mode |
        (external_expansion_enable & is_single_mode(mode));

    // Column/wait roles: bus controller or function control
    assign col_sel = expanded ? (bus_mode ? bc_column_wait_en
                                          : port_function_ctrl2)
                              : 3'h0;

    assign bus_role[7] = pin_direction_select[7];
    assign bus_role[6] = expanded & addr_strobe_out_enable;
    assign bus_role[5] = expanded;
    assign bus_role[4] = expanded;
    assign bus_role[3] = expanded & low_write_strobe_out_enable;
    assign bus_role[2] = col_sel[2];
    assign bus_role[1] = col_sel[1];
    assign bus_role[0] = col_sel[0];

    assign role_out = {sys_clk_level, address_strobe, read_strobe,
                       high_write_strobe, low_write_strobe,
                       lower_column_strobe, upper_column_strobe, 1'b0};
    // Wait is the only bus role that listens
    assign role_oe_n = 8'h01;

    assign pin_out  = (bus_role & role_out) |
                      (~bus_role & pin_output_latch);
    assign pin_oe_n = (bus_role & role_oe_n) |
                      (~bus_role & ~pin_direction_select);

endmodule // port_f_pin_select

`default_nettype wire

// File: rtl/port_f_pin_mux.sv
// Purpose: Port F registers, AXI4-Lite slave and pin multiplexer
// Assumes: Operating mode comes from system control on aclk
// Notes:   One write and one read in flight at a time
//
// Local design decisions: the address map and the AXI4-Lite register port.

`timescale 1ns/10ps
`default_nettype none

module port_f_pin_mux
    import port_f_pkg::*;
#(
    parameter logic [7:0] DIR_READ_VALUE = DIR_READ_DEFAULT
)
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // System control
    input  wire logic [2:0]        op_mode,
    input  wire logic              sys_clk_level,
    // Bus controller strobes
    input  wire logic              address_strobe,
    input  wire logic              read_strobe,
    input  wire logic              high_write_strobe,
    input  wire logic              low_write_strobe,
    input  wire logic              lower_column_strobe,
    input  wire logic              upper_column_strobe,
    // Bus controller column/wait enables {lower, upper, wait}
    input  wire logic [2:0]        bc_column_wait_en,
    // Wait level to bus controller
    output logic                   wait_level,
    // Pins
    input  wire logic [7:0]        pin_in,
    output logic      [7:0]        pin_out,
    output logic      [7:0]        pin_oe_n
);

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;

    wr_state_e         wr_state_r;
    wr_state_e         wr_state_nxt;
    rd_state_e         rd_state_r;
    rd_state_e         rd_state_nxt;

    // Write channel holding
    logic              aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic              w_held_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic [1:0]        bresp_r;

    // Read channel
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    // Port registers
    logic [7:0]        dir_r;
    logic [7:0]        latch_r;
    logic [CFG_W-1:0]  cfg_r;
    logic [2:0]        mode_r;

    // Pin synchroniser
    logic [7:0]        pin_meta_r;
    logic [7:0]        pin_sync_r;

    // Decode and control wires
    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              wr_go;
    logic              byte0_en;
    logic              hit_w_dir;
    logic              hit_w_latch;
    logic              hit_w_cfg;
    logic              hit_w_status;
    logic              hit_w_any;
    logic              hit_r_dir;
    logic              hit_r_latch;
    logic              hit_r_cfg;
    logic              hit_r_status;
    logic              hit_r_any;
    logic              wr_dir;
    logic              wr_latch;
    logic              wr_cfg;
    logic [7:0]        bus_role;
    logic [7:0]        drive_map;
    logic [31:0]       status_word;
    logic [31:0]       rd_mux;

    // Handshakes
    assign s_axi_awready = !aw_held_r && (wr_state_r == WR_IDLE);
    assign s_axi_wready  = !w_held_r && (wr_state_r == WR_IDLE);
    assign s_axi_arready = (rd_state_r == RD_IDLE);
    assign s_axi_bvalid  = (wr_state_r == WR_RESP);
    assign s_axi_rvalid  = (rd_state_r == RD_RESP);
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    // Commit once both halves of a write are held
    assign wr_go   = aw_held_r && w_held_r && (wr_state_r == WR_IDLE);

    // Write address decode
    assign hit_w_dir    = reg_hit(aw_addr_r, OFF_DIR);
    assign hit_w_latch  = reg_hit(aw_addr_r, OFF_LATCH);
    assign hit_w_cfg    = reg_hit(aw_addr_r, OFF_CFG);
    assign hit_w_status = reg_hit(aw_addr_r, OFF_STATUS);
    assign hit_w_any    = hit_w_dir | hit_w_latch | hit_w_cfg |
                          hit_w_status;

    assign byte0_en = w_strb_r[0];
    assign wr_dir   = wr_go && hit_w_dir && byte0_en;
    assign wr_latch = wr_go && hit_w_latch && byte0_en;
    assign wr_cfg   = wr_go && hit_w_cfg && byte0_en;

    // Read address decode
    assign hit_r_dir    = reg_hit(s_axi_araddr, OFF_DIR);
    assign hit_r_latch  = reg_hit(s_axi_araddr, OFF_LATCH);
    assign hit_r_cfg    = reg_hit(s_axi_araddr, OFF_CFG);
    assign hit_r_status = reg_hit(s_axi_araddr, OFF_STATUS);
    assign hit_r_any    = hit_r_dir | hit_r_latch | hit_r_cfg |
                          hit_r_status;

    assign drive_map   = ~pin_oe_n;
    assign status_word = {12'h000, pin_sync_r, 1'b0, mode_r, drive_map};

    // Direction reads return a fixed pattern, not the stored bits
    assign rd_mux = hit_r_dir    ? {24'h000000, DIR_READ_VALUE} :
                    hit_r_latch  ? {24'h000000, latch_r} :
                    hit_r_cfg    ? {26'h0000000, cfg_r} :
                    hit_r_status ? status_word :
                                   32'h00000000;

    // Write state machine
    always_comb begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            WR_IDLE: begin
                if (wr_go) begin
                    wr_state_nxt = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_nxt = WR_IDLE;
                end
            end
            default: wr_state_nxt = WR_IDLE;
        endcase
    end

    // Read state machine
    always_comb begin
        rd_state_nxt = rd_state_r;
        case (rd_state_r)
            RD_IDLE: begin
                if (ar_take) begin
                    rd_state_nxt = RD_RESP;
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_nxt = RD_IDLE;
                end
            end
            default: rd_state_nxt = RD_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= WR_IDLE;
            rd_state_r <= RD_IDLE;
        end else begin
            wr_state_r <= wr_state_nxt;
            rd_state_r <= rd_state_nxt;
        end
    end

    // Write address hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    // Write data hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bresp_r <= hit_w_any ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            rdata_r <= rd_mux;
            rresp_r <= hit_r_any ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Mode is caught during reset; bit 7 direction depends on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= op_mode;
            dir_r  <= {is_bus_mode(op_mode), DIR_LO_RST};
        end else if (wr_dir) begin
            dir_r  <= w_data_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_r <= LATCH_RST;
        end else if (wr_latch) begin
            latch_r <= w_data_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= w_data_r[CFG_W-1:0];
        end
    end

    // Two-flop synchroniser on pin levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Wait level only means something while pin 0 holds its bus role
    assign wait_level = pin_sync_r[0] & bus_role[0];

    port_f_pin_select u_pin_select (
        .mode                        (mode_r),
        .external_expansion_enable   (cfg_r[CFG_EXTERNAL_EXPANSION_ENABLE]),
        .addr_strobe_out_enable      (cfg_r[CFG_ADDR_STROBE_OUT_ENABLE]),
        .low_write_strobe_out_enable (cfg_r[CFG_LOW_WRITE_STROBE_OUT_ENABLE]),
        .port_function_ctrl2         ({cfg_r[CFG_LOWER_COLUMN_STROBE], cfg_r[CFG_UPPER_COLUMN_STROBE],
                                       cfg_r[CFG_WAIT]}),
        .bc_column_wait_en           (bc_column_wait_en),
        .pin_direction_select        (dir_r),
        .pin_output_latch            (latch_r),
        .sys_clk_level               (sys_clk_level),
        .address_strobe              (address_strobe),
        .read_strobe                 (read_strobe),
        .high_write_strobe           (high_write_strobe),
        .low_write_strobe            (low_write_strobe),
        .lower_column_strobe         (lower_column_strobe),
        .upper_column_strobe         (upper_column_strobe),
        .pin_out                     (pin_out),
        .pin_oe_n                    (pin_oe_n),
        .bus_role                    (bus_role)
    );

endmodule // port_f_pin_mux

`default_nettype wire

// File: test/port_f_pin_mux_properties.sv
// Purpose: Pin function and bus answer checks for port_f_pin_mux
// Assumes: Bound to the top module, single aclk domain
// Notes:   Mode is captured during reset as the block does

`timescale 1ns/10ps
`default_nettype none

module port_f_pin_mux_properties
    import port_f_pkg::*;
#(
    parameter logic [7:0] DIR_READ_VALUE = DIR_READ_DEFAULT
)
(
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Register bus
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    // Mode and strobes
    input wire logic [2:0]        op_mode,
    input wire logic              sys_clk_level,
    input wire logic              read_strobe,
    input wire logic              high_write_strobe,
    input wire logic              lower_column_strobe,
    input wire logic              upper_column_strobe,
    input wire logic [2:0]        bc_column_wait_en,
    // Pins
    input wire logic [7:0]        pin_out,
    input wire logic [7:0]        pin_oe_n
);
    logic [2:0]        mode_r;
    logic [ADDR_W-1:0] ar_r;
    wire               bus_mode = mode_r inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

    always_ff @(posedge aclk) begin
        if (!aresetn)
            mode_r <= op_mode;
        if (s_axi_arvalid && s_axi_arready)
            ar_r <= s_axi_araddr;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pin7_clock_a: assert property (!pin_oe_n[7] |-> pin_out[7] == sys_clk_level)
        else $error("pin 7 not on system clock");
    clk_dir_reset_a: assert property ($rose(aresetn) |-> pin_oe_n[7] == !bus_mode)
        else $error("pin 7 direction wrong after reset");
    strobe_force_a: assert property (bus_mode |-> pin_oe_n[5:4] == 2'h0
        && pin_out[5:4] == {read_strobe, high_write_strobe})
        else $error("read or high write strobe not forced");
    lower_column_strobe_role_a: assert property (bus_mode && bc_column_wait_en[2]
        |-> !pin_oe_n[2] && pin_out[2] == lower_column_strobe)
        else $error("lower column strobe missing");
    upper_column_strobe_role_a: assert property (bus_mode && bc_column_wait_en[1]
        |-> !pin_oe_n[1] && pin_out[1] == upper_column_strobe)
        else $error("upper column strobe missing");
    wait_input_a: assert property (bus_mode && bc_column_wait_en[0] |-> pin_oe_n[0])
        else $error("wait pin is driven");
    dir_read_a: assert property (s_axi_rvalid && ar_r[7:2] == 6'h00
        |-> s_axi_rdata == {24'h0, DIR_READ_VALUE})
        else $error("direction bits read back");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");

    cover property (bus_mode && bc_column_wait_en[0]);
    cover property (s_axi_rvalid && ar_r == 8'h00);
    cover property ($rose(aresetn) && bus_mode);

endmodule // port_f_pin_mux_properties

bind port_f_pin_mux port_f_pin_mux_properties #(
    .DIR_READ_VALUE(DIR_READ_VALUE)
) chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .op_mode, .sys_clk_level,
    .read_strobe, .high_write_strobe, .lower_column_strobe,
    .upper_column_strobe, .bc_column_wait_en, .pin_out, .pin_oe_n);

`default_nettype wire

// File: test/port_f_board.sv
// Purpose: Board seen by the port F pins
// Assumes: No pull-ups; undriven pins follow the board level
// Notes:   Driven pins read back their own drive

`timescale 1ns/10ps
`default_nettype none

module port_f_board (
    // Block pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    // Board levels
    input wire logic [7:0] ext_level,
    output logic     [7:0] pin_in
);
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule // port_f_board

`default_nettype wire

// File: test/port_f_direction_and_pin_mux_test.sv
// Purpose: Register and pin function tests for port_f_pin_mux
// Assumes: 40 MHz aclk, AXI4-Lite master tasks
// Notes:   Strobe levels change between tests to catch swaps

`timescale 1ns/10ps
`default_nettype none

module port_f_direction_and_pin_mux_test;
    import port_f_pkg::*;
    logic        aclk = 0, aresetn = 0, sys_clk_level = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, ext_level = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, wait_level;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  op_mode = 3'h7, bc_column_wait_en = 0;
    logic [5:0]  strb = 6'h2D;
    logic [7:0]  pin_in, pin_out, pin_oe_n;
    logic [2:0]  bus_modes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int          n_mismatch = 0, checked = 0;

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) sys_clk_level <= ~sys_clk_level;

    port_f_pin_mux DUT (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .op_mode, .sys_clk_level,
        .address_strobe(strb[5]), .read_strobe(strb[4]),
        .high_write_strobe(strb[3]), .low_write_strobe(strb[2]),
        .lower_column_strobe(strb[1]), .upper_column_strobe(strb[0]),
        .bc_column_wait_en, .wait_level, .pin_in, .pin_out, .pin_oe_n);

    port_f_board board (.pin_out, .pin_oe_n, .ext_level, .pin_in);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task rst(input logic [2:0] m);
        @(posedge aclk);
        aresetn <= 0;
        op_mode <= m;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask

    // Ready levels are read at the falling edge, before the edge that uses them
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw_ok, w_ok, b_ok;
        logic [1:0] resp;
        b_ok = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = s_axi_awready;
            w_ok = s_axi_wready;
            b_ok = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 0;
            if (w_ok) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        check(resp, er);
    endtask

    task rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        ar_ok, r_ok;
        logic [1:0]  resp;
        logic [31:0] data;
        r_ok = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = s_axi_arready;
            r_ok = s_axi_rvalid;
            resp = s_axi_rresp;
            data = s_axi_rdata;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
        check(resp, er);
        if (er == RESP_OKAY) check(data, ed);
    endtask

    // Expected drive: bus levels where busm is set, latch elsewhere
    task pins(input logic [7:0] eo, input logic [7:0] lat,
              input logic [7:0] busm);
        logic [7:0] ex;
        @(posedge aclk);
        #1;
        ex = (busm & {sys_clk_level, strb, 1'b0}) | (~busm & lat);
        check(pin_oe_n, eo);
        check(pin_out & ~eo, ex & ~eo);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        finish_test;
    end

    initial begin
        rst(3'h7);
        rdr(OFF_LATCH, 32'h0, RESP_OKAY);
        rdr(OFF_DIR, {24'h0, DIR_READ_DEFAULT}, RESP_OKAY);
        pins(8'hFF, 8'h00, 8'h80);
        wr(OFF_DIR, 32'hFF, RESP_OKAY);
        wr(OFF_LATCH, 32'h5A, RESP_OKAY);
        rdr(OFF_DIR, {24'h0, DIR_READ_DEFAULT}, RESP_OKAY);
        pins(8'h00, 8'h5A, 8'h80);
        rdr(OFF_LATCH, 32'h5A, RESP_OKAY);
        wr(8'h10, 32'h0, RESP_SLVERR);
        rdr(8'h10, 32'h0, RESP_SLVERR);
        $display("test single chip done");
        strb <= ~strb;
        wr(OFF_DIR, 32'h00, RESP_OKAY);
        wr(OFF_CFG, 32'h07, RESP_OKAY);
        pins(8'h87, 8'h00, 8'hF8);
        ext_level <= 8'h01;
        wr(OFF_CFG, 32'h39, RESP_OKAY);
        pins(8'hC9, 8'h00, 8'hB6);
        repeat (4) @(posedge aclk);
        check(wait_level, 1'b1);
        ext_level <= 8'h00;
        wr(OFF_DIR, 32'hFF, RESP_OKAY);
        pins(8'h01, 8'h5A, 8'hB6);
        repeat (4) @(posedge aclk);
        check(wait_level, 1'b0);
        $display("test expansion done");
        rst(3'h3);
        pins(8'hFF, 8'h00, 8'h80);
        wr(OFF_CFG, 32'h01, RESP_OKAY);
        pins(8'hCF, 8'h00, 8'h30);
        foreach (bus_modes[i]) begin
            strb <= strb + 6'h13;
            rst(bus_modes[i]);
            rdr(OFF_CFG, {26'h0, CFG_RST}, RESP_OKAY);
            pins(8'h07, 8'h00, 8'hF8);
        end
        bc_column_wait_en <= 3'h7;
        pins(8'h01, 8'h00, 8'hFE);
        bc_column_wait_en <= 3'h0;
        wr(OFF_DIR, 32'h06, RESP_OKAY);
        wr(OFF_LATCH, 32'hFF, RESP_OKAY);
        pins(8'h81, 8'hFF, 8'h78);
        wr(OFF_CFG, 32'h00, RESP_OKAY);
        pins(8'hC9, 8'hFF, 8'h30);
        wr(OFF_DIR, 32'h48, RESP_OKAY);
        pins(8'h87, 8'hFF, 8'h30);
        $display("test bus modes done");
        finish_test;
    end
endmodule // port_f_direction_and_pin_mux_test

`default_nettype wire
